// >>> hdl/mcb_pkg.sv
package mcb_pkg;
  localparam int NBANK      = 5;
  localparam int MAIN_BANK  = 4;
  // status word field positions
  localparam int CODE_LSB   = 0;
  localparam int MODEL_LSB  = 16;
  localparam int INFO_LSB   = 32;
  localparam int INFO_W     = 25;
  localparam int CNT_LSB    = 0;
  localparam int FMT_LSB    = 8;
  localparam int PCC_BIT    = 57;
  localparam int ADDRESS_PRESENT_FLAG_BIT  = 58;
  localparam int EXTRA_INFO_PRESENT_FLAG_BIT  = 59;
  localparam int EN_BIT     = 60;
  localparam int UC_BIT     = 61;
  localparam int OVER_BIT   = 62;
  localparam int VAL_BIT    = 63;
  // main bank architectural codes
  localparam logic [15:0] CODE_INTERNAL = 16'h0400;
  localparam logic [15:0] CODE_L3TAG    = 16'h010B;
  localparam logic [15:0] CODE_BUS      = 16'h0E0F;
  // correctable event count
  localparam logic [7:0]  CNT_MAX   = 8'hFF;
  localparam logic [7:0]  CNT_STEP  = 8'h01;
  // register map: bank stride 16 bytes
  localparam logic [1:0]  OFS_LO    = 2'h0;
  localparam logic [1:0]  OFS_HI    = 2'h1;
  localparam logic [1:0]  OFS_CTL   = 2'h2;
  // reset values
  localparam logic [63:0] STAT_RST  = 64'h0;
  localparam logic [31:0] CTL_RST   = 32'h0;
  localparam logic [7:0]  CNT_RST   = 8'h00;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  typedef enum logic [1:0] {
    KIND_INTERNAL = 2'h0,
    KIND_L3TAG    = 2'h1,
    KIND_BUS      = 2'h2
  } mcb_kind_t;
  typedef struct packed {
    logic        vld;
    logic [2:0]  bank;
    mcb_kind_t   kind;
    logic [15:0] arch;
    logic [15:0] model;
    logic        uc;
    logic        context_corrupt_flag;
    logic        address_present_flag;
    logic        extra_info_present_flag;
    logic [1:0]  fmt;
    logic [4:0]  ctl_bit;
  } mcb_err_t;
endpackage : mcb_pkg

// >>> hdl/mcb_error_log_bank.sv
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module mcb_error_log_bank
  import mcb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire mcb_err_t    err
);

  // ****************************************
  // bus address phase
  // ****************************************

  logic        acc;
  logic [2:0]  a_bank;
  logic [1:0]  a_ofs;
  logic        a_ok;
  logic        wr_pend_r;
  logic [2:0]  wr_bank_r;
  logic [1:0]  wr_ofs_r;
  logic        wr_ok_r;
  logic        hready_r;
  logic        hresp_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_word;

  // transfer taken on nonseq, word size assumed
  assign acc    = hsel & hready & (htrans == HTRANS_NSEQ);
  assign a_bank = haddr[6:4];
  assign a_ofs  = haddr[3:2];
  // unmapped words read zero, writes dropped
  assign a_ok   = (haddr[31:7] == 25'h0) & (haddr[1:0] == 2'h0)
                & (a_bank < 3'(NBANK)) & (a_ofs != 2'h3);

  // capture write target for data phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend_r <= 1'b0;
      wr_bank_r <= 3'h0;
      wr_ofs_r  <= 2'h0;
      wr_ok_r   <= 1'b0;
    end
    else if (ce)
    begin
      wr_pend_r <= acc & hwrite;
      wr_bank_r <= a_bank;
      wr_ofs_r  <= a_ofs;
      wr_ok_r   <= a_ok;
    end
  end

  // zero wait state, always okay
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
    end
    else if (ce)
    begin
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
    end
  end

  // read data registered at address phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hrdata_r <= 32'h0;
    else if (ce)
      hrdata_r <= (acc & !hwrite) ? rd_word : 32'h0;
  end

  assign hreadyout = hready_r;
  assign hresp     = hresp_r;
  assign hrdata    = hrdata_r;

  // ****************************************
  // bank storage
  // ****************************************

  logic [63:0] stat_r   [NBANK];
  logic [63:0] stat_nxt [NBANK];
  logic [31:0] ctl_r    [NBANK];
  logic [63:0] new_word [NBANK];
  logic [NBANK-1:0] hit_v;
  logic [NBANK-1:0] take_v;
  logic [NBANK-1:0] sw_lo_v;
  logic [NBANK-1:0] sw_hi_v;
  logic [NBANK-1:0] sw_ctl_v;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic [15:0] main_code;
  logic        corr_main;

  // read mux over banks
  always_comb
  begin
    rd_word = 32'h0;
    if (a_ok)
    begin
      unique case (a_ofs)
        OFS_LO:  rd_word = stat_r[a_bank][31:0];
        OFS_HI:  rd_word = stat_r[a_bank][63:32];
        OFS_CTL: rd_word = ctl_r[a_bank];
        default: rd_word = 32'h0;
      endcase
    end
  end

  // main bank code from error kind
  always_comb
  begin
    unique case (err.kind)
      KIND_INTERNAL: main_code = CODE_INTERNAL;
      KIND_L3TAG:    main_code = CODE_L3TAG;
      KIND_BUS:      main_code = CODE_BUS;
      default:       main_code = CODE_INTERNAL;
    endcase
  end

  // ****************************************
  // correctable event counter
  // ****************************************

  assign corr_main = err.vld & (err.bank == 3'(MAIN_BANK)) & !err.uc;

  // saturating count, first event gives one
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (corr_main && (cnt_r != CNT_MAX))
      cnt_nxt = cnt_r + CNT_STEP;
  end

  // only reset clears the count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= CNT_RST;
    else if (ce)
      cnt_r <= cnt_nxt;
  end

  // ****************************************
  // per bank logging
  // ****************************************

  genvar i;
  generate
    for (i = 0; i < NBANK; i++)
    begin : g_bank
      logic en_new;
      logic [INFO_W-1:0] info;

      assign hit_v[i]    = err.vld & (err.bank == 3'(i));
      assign sw_lo_v[i]  = wr_pend_r & wr_ok_r & (wr_bank_r == 3'(i))
                         & (wr_ofs_r == OFS_LO);
      assign sw_hi_v[i]  = wr_pend_r & wr_ok_r & (wr_bank_r == 3'(i))
                         & (wr_ofs_r == OFS_HI);
      assign sw_ctl_v[i] = wr_pend_r & wr_ok_r & (wr_bank_r == 3'(i))
                         & (wr_ofs_r == OFS_CTL);

      // armed only for uncorrected with control bit
      assign en_new = err.uc & ctl_r[i][err.ctl_bit];

      // overwrite priority against held entry
      assign take_v[i] = !stat_r[i][VAL_BIT]
        | (!(stat_r[i][UC_BIT] & err.uc)
           & ((en_new & !stat_r[i][EN_BIT])
              | (err.uc & !stat_r[i][UC_BIT])));

      // implementation info: count and format, main bank only, zero elsewhere
      always_comb
      begin
        info = '0;
        if (i == MAIN_BANK)
        begin
          info[CNT_LSB +: 8] = cnt_nxt;
          info[FMT_LSB +: 2] = err.fmt;
        end
      end

      // compose the incoming entry
      always_comb
      begin
        new_word[i] = STAT_RST;
        new_word[i][CODE_LSB +: 16] = (i == MAIN_BANK) ?
          main_code : err.arch;
        new_word[i][MODEL_LSB +: 16] = err.model;
        new_word[i][INFO_LSB +: INFO_W] = info;
        new_word[i][PCC_BIT]   = err.context_corrupt_flag | err.uc;
        new_word[i][ADDRESS_PRESENT_FLAG_BIT] = err.address_present_flag;
        new_word[i][EXTRA_INFO_PRESENT_FLAG_BIT] = err.extra_info_present_flag;
        new_word[i][EN_BIT]    = en_new;
        new_word[i][UC_BIT]    = err.uc;
        new_word[i][OVER_BIT]  = stat_r[i][VAL_BIT]
                               | stat_r[i][OVER_BIT];
        new_word[i][VAL_BIT]   = 1'b1;
      end

      // software write first, hardware set wins
      always_comb
      begin
        stat_nxt[i] = stat_r[i];
        if (sw_lo_v[i])
          stat_nxt[i][31:0] = hwdata;
        if (sw_hi_v[i])
          stat_nxt[i][63:32] = hwdata;
        if (hit_v[i] & take_v[i])
          stat_nxt[i] = new_word[i];
        else if (hit_v[i])
          stat_nxt[i][OVER_BIT] = 1'b1;
      end

      // status word storage
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          stat_r[i] <= STAT_RST;
        else if (ce)
          stat_r[i] <= stat_nxt[i];
      end

      // reporting control storage
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          ctl_r[i] <= CTL_RST;
        else if (ce && sw_ctl_v[i])
          ctl_r[i] <= hwdata;
      end
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_main_code_legal: assert property (
    ce & hit_v[MAIN_BANK] & take_v[MAIN_BANK] |=>
      (stat_r[MAIN_BANK][15:0] == CODE_INTERNAL)
      | (stat_r[MAIN_BANK][15:0] == CODE_L3TAG)
      | (stat_r[MAIN_BANK][15:0] == CODE_BUS))
    else $error("main bank code not legal");

  chk_pcc_on_uc: assert property (
    ce & hit_v[0] & take_v[0] & err.uc |=>
      stat_r[0][PCC_BIT] & stat_r[0][UC_BIT])
    else $error("context corrupt missing");

  chk_en_corr_clear: assert property (
    ce & hit_v[0] & take_v[0] & !err.uc |=>
      !stat_r[0][EN_BIT] & !stat_r[0][UC_BIT])
    else $error("armed flag set on correctable");

  chk_over_set: assert property (
    ce & hit_v[MAIN_BANK] & stat_r[MAIN_BANK][VAL_BIT] |=>
      stat_r[MAIN_BANK][OVER_BIT])
    else $error("repeat flag not set");

  chk_uc_kept: assert property (
    ce & hit_v[MAIN_BANK] & err.uc & stat_r[MAIN_BANK][VAL_BIT]
      & stat_r[MAIN_BANK][UC_BIT] & !sw_lo_v[MAIN_BANK] |=>
      stat_r[MAIN_BANK][31:0] == $past(stat_r[MAIN_BANK][31:0]))
    else $error("uncorrected entry overwritten");

  chk_val_set: assert property (
    ce & hit_v[1] |=> stat_r[1][VAL_BIT])
    else $error("entry flag not set");

  chk_over_sticky: assert property (
    stat_r[1][OVER_BIT] & !(ce & sw_hi_v[1]) |=>
      stat_r[1][OVER_BIT])
    else $error("repeat flag lost");

  chk_cnt_sat: assert property (
    ce & corr_main & (cnt_r == CNT_MAX) |=> cnt_r == CNT_MAX)
    else $error("count wrapped");

  chk_cnt_first: assert property (
    ce & corr_main & (cnt_r == CNT_RST) |=>
      (cnt_r == CNT_STEP)
      & (!$past(take_v[MAIN_BANK]) | (stat_r[MAIN_BANK][39:32] == CNT_STEP)))
    else $error("first count not one");

  chk_cnt_step: assert property (
    ce & corr_main & (cnt_r != CNT_MAX) |=> cnt_r == $past(cnt_r) + CNT_STEP)
    else $error("count did not step");

  chk_en_follow: assert property (
    ce & hit_v[2] & take_v[2] & err.uc & ctl_r[2][err.ctl_bit] |=>
      stat_r[2][EN_BIT])
    else $error("armed flag missing");

  chk_pcc_main: assert property (
    ce & hit_v[MAIN_BANK] & take_v[MAIN_BANK] & err.uc |=>
      stat_r[MAIN_BANK][PCC_BIT])
    else $error("main bank context corrupt missing");

  chk_address_present_flag_copy: assert property (
    ce & hit_v[MAIN_BANK] & take_v[MAIN_BANK] |=>
      stat_r[MAIN_BANK][ADDRESS_PRESENT_FLAG_BIT] == $past(err.address_present_flag))
    else $error("address present flag wrong");

  chk_extra_info_present_flag_copy: assert property (
    ce & hit_v[MAIN_BANK] & take_v[MAIN_BANK] |=>
      stat_r[MAIN_BANK][EXTRA_INFO_PRESENT_FLAG_BIT] == $past(err.extra_info_present_flag))
    else $error("extra info present flag wrong");

  chk_uc_copy: assert property (
    ce & hit_v[MAIN_BANK] & take_v[MAIN_BANK] |=>
      stat_r[MAIN_BANK][UC_BIT] == $past(err.uc))
    else $error("uncorrected flag wrong");

  chk_uc_replace: assert property (
    ce & hit_v[3] & err.uc & stat_r[3][VAL_BIT] & !stat_r[3][UC_BIT] |=>
      stat_r[3][UC_BIT] & (stat_r[3][31:16] == $past(err.model)))
    else $error("uncorrected did not replace");

  chk_model_whole: assert property (
    ce & hit_v[MAIN_BANK] & take_v[MAIN_BANK] |=>
      (stat_r[MAIN_BANK][31:16] == $past(err.model)) & stat_r[MAIN_BANK][VAL_BIT])
    else $error("status word not whole");

  chk_ready_high: assert property (
    hreadyout & !hresp)
    else $error("bus not ready or error");

endmodule : mcb_error_log_bank
`default_nettype wire

// >>> verification/mcb_error_log_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mcb_error_log_bank_tb
  import mcb_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [63:0] w;
  logic [63:0] exp4;
  logic [7:0]  cnt;
  mcb_err_t    err;
  mcb_err_t    e;
  int          errors;
  int          n_checks;

  mcb_error_log_bank DUT (
    .clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .err(err)
  );

  // ********************************
  // clock, bus sampling
  // ********************************
  always #4 clk = ~clk;

  // ********************************
  // tasks
  // ********************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ready as it stood just before the edge
  task automatic edge_rdy;
    do
      @(posedge clk);
    while (hreadyout !== 1'b1);
  endtask : edge_rdy

  // one single AHB-Lite transfer, address then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NSEQ;
    hwrite <= wr;
    edge_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    // read data and response taken at the data phase edge
    q = hrdata;
    chk({63'h0, hresp}, 64'h0);
  endtask : bus

  // only status halves are read, never the control word
  task automatic rd64(input logic [2:0] b);
    bus(1'b0, {25'h0, b, 4'h0}, 32'h0);
    w[31:0] = q;
    bus(1'b0, {25'h0, b, 4'h4}, 32'h0);
    w[63:32] = q;
  endtask : rd64

  // one-cycle error pulse; tracks the correctable count
  task automatic fire(input mcb_err_t x);
    @(posedge clk);
    err <= x;
    @(posedge clk);
    err <= '0;
    if (x.bank == 3'h4 && !x.uc && cnt != CNT_MAX)
      cnt = cnt + CNT_STEP;
  endtask : fire

  function automatic mcb_err_t ev(input logic [2:0] b, input mcb_kind_t k,
                                  input logic [15:0] a, input logic uc, input logic [4:0] cb);
    ev = '{1'b1, b, k, a, ~a, uc, 1'b0, ~uc, uc, {uc, 1'b1}, cb};
  endfunction : ev

  // expected status word
  function automatic logic [63:0] mk(input mcb_err_t x, input logic [15:0] code,
                                     input logic en, input logic ov, input logic [24:0] inf);
    mk = {1'b1, ov, x.uc, en, x.extra_info_present_flag, x.address_present_flag, x.context_corrupt_flag | x.uc, inf, x.model, code};
  endfunction : mk

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // ********************************
  // tests
  // ********************************
  initial
  begin
    clk = 1'b0; nrst = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hwdata = 32'h0; err = '0; cnt = 8'h00; errors = 0; n_checks = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    // reset state of all banks
    for (int b = 0; b < NBANK; b++)
    begin
      rd64(3'(b));
      chk(w, STAT_RST);
    end
    bus(1'b1, 32'h0000_0050, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0050, 32'h0);
    chk({32'h0, q}, 64'h0);
    // frozen while clock enable is low
    ce <= 1'b0;
    fire(ev(3'h2, KIND_INTERNAL, 16'h1234, 1'b1, 5'h00));
    ce <= 1'b1;
    rd64(3'h2);
    chk(w, STAT_RST);
    // correctable tag error, all control bits set
    bus(1'b1, 32'h0000_0048, 32'hFFFF_FFFF);
    e = ev(3'h4, KIND_L3TAG, 16'h0000, 1'b0, 5'h03);
    fire(e);
    rd64(3'h4);
    exp4 = mk(e, CODE_L3TAG, 1'b0, 1'b0, {15'h0, e.fmt, cnt});
    chk(w, exp4);
    // second correctable only marks the repeat
    fire(ev(3'h4, KIND_BUS, 16'h0000, 1'b0, 5'h05));
    rd64(3'h4);
    exp4[OVER_BIT] = 1'b1;
    chk(w, exp4);
    // armed uncorrected bus error replaces it
    e = ev(3'h4, KIND_BUS, 16'h0000, 1'b1, 5'h07);
    fire(e);
    rd64(3'h4);
    exp4 = mk(e, CODE_BUS, 1'b1, 1'b1, {15'h0, e.fmt, cnt});
    chk(w, exp4);
    // software clears the upper half
    bus(1'b1, 32'h0000_0044, 32'h0);
    rd64(3'h4);
    chk(w, {32'h0, exp4[31:0]});
    // uncorrected internal, then a second uncorrected is kept out
    e = ev(3'h4, KIND_INTERNAL, 16'h0000, 1'b1, 5'h02);
    fire(e);
    exp4 = mk(e, CODE_INTERNAL, 1'b1, 1'b0, {15'h0, e.fmt, cnt});
    fire(ev(3'h4, mcb_kind_t'(2'h3), 16'hFFFF, 1'b1, 5'h04));
    rd64(3'h4);
    exp4[OVER_BIT] = 1'b1;
    chk(w, exp4);
    // plain banks: enabled uncorrected over correctable
    for (int b = 0; b < 4; b++)
    begin
      bus(1'b1, {25'h0, 3'(b), 4'h8}, 32'h1 << b);
      fire(ev(3'(b), KIND_INTERNAL, 16'h1100 + 16'(b), 1'b0, 5'(b)));
      e = ev(3'(b), KIND_INTERNAL, 16'h2200 + 16'(b), 1'b1, 5'(b));
      fire(e);
      rd64(3'(b));
      chk(w, mk(e, e.arch, 1'b1, 1'b1, 25'h0));
    end
    // correctable count saturates
    repeat (260) fire(ev(3'h4, KIND_L3TAG, 16'h0000, 1'b0, 5'h00));
    bus(1'b1, 32'h0000_0044, 32'h0);
    e = ev(3'h4, KIND_L3TAG, 16'h0000, 1'b0, 5'h01);
    fire(e);
    rd64(3'h4);
    chk(w, mk(e, CODE_L3TAG, 1'b0, 1'b0, {15'h0, e.fmt, 8'hFF}));
    tally_and_finish();
  end

  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule : mcb_error_log_bank_tb
`default_nettype wire
